/* hdl/noload_defs.vh */
// Constants for the no-load status and pulse phase-select register bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef NOLOAD_DEFS_VH
`define NOLOAD_DEFS_VH

// Register byte addresses on the APB side.
`define ADDR_PHASE_EVENT_STATUS 16'hE600
`define ADDR_MAIN_INT_STATUS 16'hE604
`define ADDR_PHASE_NOLOAD_STATUS 16'hE608
`define ADDR_COMP_MODE_CONFIG 16'hE60C

// Field positions in phase_noload_status.
`define NL_TOTAL_LSB 0
`define NL_FUND_LSB 3
`define NL_APPARENT_LSB 6
`define NL_USED_BITS 9

// Field positions in main_interrupt_status.
`define MIS_TOTAL_BIT 0
`define MIS_FUND_BIT 1
`define MIS_APPARENT_BIT 2
`define MIS_USED_BITS 3

// Field positions in phase_event_status (over-current, over-voltage, sag).
`define PES_VALID_MASK 16'h7E38

// Field positions and reset value of computation_mode_config.
`define CMC_SEL1_LSB 0
`define CMC_SEL2_LSB 3
`define CMC_SEL3_LSB 6
`define CMC_ANGLE_LSB 9
`define CMC_USED_BITS 11
`define CMC_RESET 11'h1FF

// Angle-select codes.
`define ANGLE_V_TO_I 2'h0
`define ANGLE_V_TO_V 2'h1
`define ANGLE_I_TO_I 2'h2
`define ANGLE_NONE 2'h3

// Datapath widths.
`define POWER_W 24
`define SUM_W 26

`endif

/* hdl/noload_status_cf_phase_select.v */
// Register bank for per-phase no-load status, calibration pulse phase
// selection and angle-measurement selection, reached over APB.
// Assumes the metering datapath drives no-load levels and phase powers
// synchronous to pclk; pulse generation itself sits downstream.
//
// What this block does
// - Bits 2:0 show per-phase total no-load, live, for A, B, C.
// - Any total no-load bit rising also sets aggregate flag bit 0.
// - Without reactive measurement, total no-load uses active power only.
// - Bits 5:3 show per-phase fundamental no-load for A, B, C.
// - Any fundamental no-load bit rising also sets aggregate flag bit 1.
// - Without fundamental measurement, bits 5:3 always read zero.
// - Bits 8:6 show per-phase apparent no-load for A, B, C.
// - Any apparent no-load bit rising also sets aggregate flag bit 2.
// - Bits 15:9 of the no-load status register always read zero.
// - Config bits 2:0, reset all ones, pick phases for pulse output one.
// - Config bits 5:3, reset all ones, pick phases for pulse output two.
// - Config bits 8:6, reset all ones, pick phases for pulse output three.
// - All three bits set means the output uses the three-phase sum.
// - Angle code 00, the reset value, measures voltage-to-current angles.
// - Code 01 voltage pairs, 10 current pairs, 11 no angle measurement.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "noload_defs.vh"

module noload_status_cf_phase_select #(
    parameter HAS_REACTIVE = 1,
    parameter HAS_FUNDAMENTAL = 1
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // No-load levels from the metering datapath, one bit per phase.
    input wire [2:0] total_active_noload,
    input wire [2:0] total_reactive_noload,
    input wire [2:0] fund_active_noload,
    input wire [2:0] fund_reactive_noload,
    input wire [2:0] apparent_noload,
    // Phase event levels (over-current, over-voltage, sag fields).
    input wire [15:0] phase_event_in,
    // Per-phase powers feeding the calibration pulse outputs.
    input wire [`POWER_W-1:0] power_a,
    input wire [`POWER_W-1:0] power_b,
    input wire [`POWER_W-1:0] power_c,
    // Selected-phase sums for the three pulse generators.
    output wire [`SUM_W-1:0] calibration_pulse_out1_sum,
    output wire [`SUM_W-1:0] calibration_pulse_out2_sum,
    output wire [`SUM_W-1:0] calibration_pulse_out3_sum,
    // Angle-measurement mode enables.
    output reg angle_volt_curr_en,
    output reg angle_volt_pair_en,
    output reg angle_curr_pair_en
);

    // Address decode, used for both the read mux and the write strobes.
    function [2:0] reg_index;
        input [15:0] addr;
        begin
            case (addr)
                `ADDR_PHASE_EVENT_STATUS: reg_index = 3'h1;
                `ADDR_MAIN_INT_STATUS: reg_index = 3'h2;
                `ADDR_PHASE_NOLOAD_STATUS: reg_index = 3'h3;
                `ADDR_COMP_MODE_CONFIG: reg_index = 3'h4;
                default: reg_index = 3'h0;
            endcase
        end
    endfunction

    localparam IDX_NONE = 3'h0;
    localparam IDX_PES = 3'h1;
    localparam IDX_MIS = 3'h2;
    localparam IDX_PNL = 3'h3;
    localparam IDX_CMC = 3'h4;

    reg [15:0] phase_event_status_reg;
    reg [`NL_USED_BITS-1:0] phase_noload_status_reg;
    reg [`NL_USED_BITS-1:0] phase_noload_status_next;
    reg [`MIS_USED_BITS-1:0] main_interrupt_status_reg;
    reg [`MIS_USED_BITS-1:0] main_interrupt_status_next;
    reg [`CMC_USED_BITS-1:0] computation_mode_config_reg;
    reg [`CMC_USED_BITS-1:0] computation_mode_config_next;
    reg [31:0] read_value;

    wire [2:0] setup_index;
    wire [2:0] access_index;
    wire setup_phase;
    wire write_access;
    wire [2:0] total_noload_phase_bits;
    wire [2:0] fundamental_noload_phase_bits;
    wire [2:0] apparent_noload_phase_bits;
    wire [2:0] total_rise;
    wire [2:0] fund_rise;
    wire [2:0] apparent_rise;
    wire [2:0] pulse1_phase_select;
    wire [2:0] pulse2_phase_select;
    wire [2:0] pulse3_phase_select;
    wire [1:0] angle_measure_select;

    // The slave always finishes in one access cycle, so pready is constant.
    assign pready = 1'b1;
    assign setup_phase = psel & ~penable;
    assign setup_index = reg_index(paddr);
    assign access_index = reg_index(paddr);
    assign write_access = psel & penable & pwrite;

    // Total no-load needs both powers quiet, unless reactive is not measured.
    assign total_noload_phase_bits = (HAS_REACTIVE != 0) ?
        (total_active_noload & total_reactive_noload) : total_active_noload;
    // Fundamental no-load is forced low on variants that cannot measure it.
    assign fundamental_noload_phase_bits = (HAS_FUNDAMENTAL != 0) ?
        (fund_active_noload & fund_reactive_noload) : 3'h0;
    assign apparent_noload_phase_bits = apparent_noload;

    // Rising edges of the per-phase bits, seen in the same cycle they are stored.
    assign total_rise = total_noload_phase_bits &
        ~phase_noload_status_reg[`NL_TOTAL_LSB +: 3];
    assign fund_rise = fundamental_noload_phase_bits &
        ~phase_noload_status_reg[`NL_FUND_LSB +: 3];
    assign apparent_rise = apparent_noload_phase_bits &
        ~phase_noload_status_reg[`NL_APPARENT_LSB +: 3];

    // The per-phase status follows the datapath levels; the bus cannot write it.
    always @* begin
        phase_noload_status_next = phase_noload_status_reg;
        phase_noload_status_next[`NL_TOTAL_LSB +: 3] = total_noload_phase_bits;
        phase_noload_status_next[`NL_FUND_LSB +: 3] = fundamental_noload_phase_bits;
        phase_noload_status_next[`NL_APPARENT_LSB +: 3] = apparent_noload_phase_bits;
    end

    // Aggregate flags are sticky and cleared by writing one; a new set wins
    // over a clear in the same cycle so no event is ever lost.
    always @* begin
        main_interrupt_status_next = main_interrupt_status_reg;
        if (write_access && access_index == IDX_MIS && pstrb[0]) begin
            main_interrupt_status_next = main_interrupt_status_reg &
                ~pwdata[`MIS_USED_BITS-1:0];
        end
        if (|total_rise) begin
            main_interrupt_status_next[`MIS_TOTAL_BIT] = 1'b1;
        end
        if (|fund_rise) begin
            main_interrupt_status_next[`MIS_FUND_BIT] = 1'b1;
        end
        if (|apparent_rise) begin
            main_interrupt_status_next[`MIS_APPARENT_BIT] = 1'b1;
        end
    end

    // Configuration writes honour the two low byte lanes separately.
    always @* begin
        computation_mode_config_next = computation_mode_config_reg;
        if (write_access && access_index == IDX_CMC) begin
            if (pstrb[0]) begin
                computation_mode_config_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                computation_mode_config_next[10:8] = pwdata[10:8];
            end
        end
    end

    // State registers; the config resets with every phase selected.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_event_status_reg <= 16'h0000;
            phase_noload_status_reg <= {`NL_USED_BITS{1'b0}};
            main_interrupt_status_reg <= {`MIS_USED_BITS{1'b0}};
            computation_mode_config_reg <= `CMC_RESET;
        end else begin
            phase_event_status_reg <= phase_event_in & `PES_VALID_MASK;
            phase_noload_status_reg <= phase_noload_status_next;
            main_interrupt_status_reg <= main_interrupt_status_next;
            computation_mode_config_reg <= computation_mode_config_next;
        end
    end

    // Read mux; undefined and reserved bits read as zero.
    always @* begin
        read_value = 32'h00000000;
        case (setup_index)
            IDX_PES: read_value[15:0] = phase_event_status_reg;
            IDX_MIS: read_value[`MIS_USED_BITS-1:0] = main_interrupt_status_reg;
            IDX_PNL: read_value[`NL_USED_BITS-1:0] = phase_noload_status_reg;
            IDX_CMC: read_value[`CMC_USED_BITS-1:0] = computation_mode_config_reg;
            default: read_value = 32'h00000000;
        endcase
    end

    // Read data and error are captured in the setup cycle so they stand,
    // registered, through the whole access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h00000000 : read_value;
            pslverr <= (setup_index == IDX_NONE);
        end
    end

    // Field views of the configuration register.
    assign pulse1_phase_select = computation_mode_config_reg[`CMC_SEL1_LSB +: 3];
    assign pulse2_phase_select = computation_mode_config_reg[`CMC_SEL2_LSB +: 3];
    assign pulse3_phase_select = computation_mode_config_reg[`CMC_SEL3_LSB +: 3];
    assign angle_measure_select = computation_mode_config_reg[`CMC_ANGLE_LSB +: 2];

    // One summing stage per pulse output, each with its own phase selection.
    phase_term_sum u_sum1 (
        .pclk(pclk),
        .presetn(presetn),
        .phase_sel(pulse1_phase_select),
        .power_a(power_a),
        .power_b(power_b),
        .power_c(power_c),
        .term_sum(calibration_pulse_out1_sum)
    );

    phase_term_sum u_sum2 (
        .pclk(pclk),
        .presetn(presetn),
        .phase_sel(pulse2_phase_select),
        .power_a(power_a),
        .power_b(power_b),
        .power_c(power_c),
        .term_sum(calibration_pulse_out2_sum)
    );

    phase_term_sum u_sum3 (
        .pclk(pclk),
        .presetn(presetn),
        .phase_sel(pulse3_phase_select),
        .power_a(power_a),
        .power_b(power_b),
        .power_c(power_c),
        .term_sum(calibration_pulse_out3_sum)
    );

    // Angle mode enables are one-hot, or all low when measurement is off.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_volt_curr_en <= 1'b1;
            angle_volt_pair_en <= 1'b0;
            angle_curr_pair_en <= 1'b0;
        end else begin
            case (angle_measure_select)
                `ANGLE_V_TO_I: begin
                    angle_volt_curr_en <= 1'b1;
                    angle_volt_pair_en <= 1'b0;
                    angle_curr_pair_en <= 1'b0;
                end
                `ANGLE_V_TO_V: begin
                    angle_volt_curr_en <= 1'b0;
                    angle_volt_pair_en <= 1'b1;
                    angle_curr_pair_en <= 1'b0;
                end
                `ANGLE_I_TO_I: begin
                    angle_volt_curr_en <= 1'b0;
                    angle_volt_pair_en <= 1'b0;
                    angle_curr_pair_en <= 1'b1;
                end
                default: begin
                    angle_volt_curr_en <= 1'b0;
                    angle_volt_pair_en <= 1'b0;
                    angle_curr_pair_en <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* hdl/phase_term_sum.v */
// Sums the per-phase power of the phases selected for one calibration pulse output.
// Assumes power words are signed and synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
`include "noload_defs.vh"

module phase_term_sum (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Selection and phase powers.
    input wire [2:0] phase_sel,
    input wire [`POWER_W-1:0] power_a,
    input wire [`POWER_W-1:0] power_b,
    input wire [`POWER_W-1:0] power_c,
    // Registered sum.
    output reg [`SUM_W-1:0] term_sum
);

    wire [`SUM_W-1:0] ext_a;
    wire [`SUM_W-1:0] ext_b;
    wire [`SUM_W-1:0] ext_c;
    wire [`SUM_W-1:0] term_next;

    // Sign extension leaves two guard bits so a three-phase sum cannot wrap.
    assign ext_a = phase_sel[0] ? {{2{power_a[`POWER_W-1]}}, power_a} : {`SUM_W{1'b0}};
    assign ext_b = phase_sel[1] ? {{2{power_b[`POWER_W-1]}}, power_b} : {`SUM_W{1'b0}};
    assign ext_c = phase_sel[2] ? {{2{power_c[`POWER_W-1]}}, power_c} : {`SUM_W{1'b0}};
    // All three selected gives the full three-phase sum.
    assign term_next = ext_a + ext_b + ext_c;

    // Register the sum for the pulse generator.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_sum <= {`SUM_W{1'b0}};
        end else begin
            term_sum <= term_next;
        end
    end

endmodule
`default_nettype wire

/* sim/noload_chk.sv */
// Checker for the no-load status and phase-select register bank.
// Assumes a bind to the bank's top module; it sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "noload_defs.vh"
module noload_chk #(
    parameter HAS_REACTIVE = 1,
    parameter HAS_FUNDAMENTAL = 1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Datapath levels and angle enables.
    input wire logic [2:0] total_active_noload,
    input wire logic [2:0] total_reactive_noload,
    input wire logic [2:0] fund_active_noload,
    input wire logic [2:0] fund_reactive_noload,
    input wire logic [2:0] apparent_noload,
    input wire logic angle_volt_curr_en,
    input wire logic angle_volt_pair_en,
    input wire logic angle_curr_pair_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Expected levels; read data is latched in the setup cycle, hence the depth of two.
    wire [2:0] tot_lv = HAS_REACTIVE ? total_active_noload & total_reactive_noload
        : total_active_noload;
    wire [2:0] fund_lv = HAS_FUNDAMENTAL ? fund_active_noload & fund_reactive_noload : 3'h0;
    wire rd = psel && !penable && !pwrite;
    wire rd_nl = rd && paddr == `ADDR_PHASE_NOLOAD_STATUS;
    wire rd_mis = rd && paddr == `ADDR_MAIN_INT_STATUS;
    wire wr_cfg = psel && penable && pwrite && paddr == `ADDR_COMP_MODE_CONFIG;
    wire [1:0] wr_code = pwdata[10:9];
    wire [2:0] ang_en = {angle_volt_curr_en, angle_volt_pair_en, angle_curr_pair_en};
    property p_tot;
        rd_nl |=> prdata[2:0] == $past(tot_lv, 2);
    endproperty
    a_tot: assert property (p_tot) else $error("total no-load bits wrong");
    property p_fund;
        rd_nl |=> prdata[5:3] == $past(fund_lv, 2);
    endproperty
    a_fund: assert property (p_fund) else $error("fundamental bits wrong");
    property p_app;
        rd_nl |=> prdata[8:6] == $past(apparent_noload, 2);
    endproperty
    a_app: assert property (p_app) else $error("apparent bits wrong");
    property p_rsv;
        rd_nl |=> prdata[31:9] == 23'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_tflag;
        rd_mis && |($past(tot_lv, 1) & ~$past(tot_lv, 2)) |=> prdata[0];
    endproperty
    a_tflag: assert property (p_tflag) else $error("total flag not set");
    property p_fflag;
        rd_mis && |($past(fund_lv, 1) & ~$past(fund_lv, 2)) |=> prdata[1];
    endproperty
    a_fflag: assert property (p_fflag) else $error("fundamental flag not set");
    property p_aflag;
        rd_mis && |($past(apparent_noload, 1) & ~$past(apparent_noload, 2)) |=> prdata[2];
    endproperty
    a_aflag: assert property (p_aflag) else $error("apparent flag not set");
    // The enables follow the stored code one register stage later, two cycles after the write.
    property p_angle;
        wr_cfg |=> ##1 ang_en == (3'h4 >> $past(wr_code, 2));
    endproperty
    a_angle: assert property (p_angle) else $error("angle enables wrong");
endmodule
`default_nettype wire

/* sim/tb_noload_status_cf_phase_select.sv */
// Self-checking bench for the no-load status and phase-select register bank.
// Assumes the bank's header is on the include path; the bench is the APB master.
`timescale 1ns/10ps
`default_nettype none
`include "noload_defs.vh"
module tb_noload_status_cf_phase_select;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er;
    logic ang_vc, ang_vp, ang_cp;
    logic [15:0] paddr, pev;
    logic [31:0] pwdata, prdata, prdata2, rd, rd2, seed, w;
    logic [3:0] pstrb;
    logic [2:0] ta, tr, fa, fr, va;
    logic [`POWER_W-1:0] pa, pb, pc;
    logic [`SUM_W-1:0] s1, s2, s3;
    logic [8:0] nl, nl_new, nl2, nl2_new;
    logic [2:0] flags, flags2;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    noload_status_cf_phase_select u_noload_status_cf_phase_select (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .total_active_noload(ta), .total_reactive_noload(tr), .fund_active_noload(fa),
        .fund_reactive_noload(fr), .apparent_noload(va), .phase_event_in(pev), .power_a(pa),
        .power_b(pb), .power_c(pc), .calibration_pulse_out1_sum(s1),
        .calibration_pulse_out2_sum(s2), .calibration_pulse_out3_sum(s3),
        .angle_volt_curr_en(ang_vc), .angle_volt_pair_en(ang_vp), .angle_curr_pair_en(ang_cp));
    // Variant without reactive or fundamental measurement, on the same bus and levels.
    noload_status_cf_phase_select #(.HAS_REACTIVE(0), .HAS_FUNDAMENTAL(0))
        u_noload_status_cf_phase_select_lite (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata2), .pready(), .pslverr(), .total_active_noload(ta),
        .total_reactive_noload(tr), .fund_active_noload(fa), .fund_reactive_noload(fr),
        .apparent_noload(va), .phase_event_in(pev), .power_a(pa), .power_b(pb),
        .power_c(pc), .calibration_pulse_out1_sum(), .calibration_pulse_out2_sum(),
        .calibration_pulse_out3_sum(), .angle_volt_curr_en(), .angle_volt_pair_en(),
        .angle_curr_pair_en());
    // Free-running clock; the timeout counter cuts a hang short.
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Model of one pulse sum: sign-extended powers of the chosen phases.
    function logic [`SUM_W-1:0] tsum(input logic [2:0] sel);
        tsum = '0;
        if (sel[0]) tsum = tsum + {{2{pa[23]}}, pa};
        if (sel[1]) tsum = tsum + {{2{pb[23]}}, pb};
        if (sel[2]) tsum = tsum + {{2{pc[23]}}, pc};
    endfunction
    // Model of the aggregate flags: one per group, set when any phase bit goes 0 to 1.
    function logic [2:0] rises(input logic [8:0] n, input logic [8:0] o);
        rises = {|(n[8:6] & ~o[8:6]), |(n[5:3] & ~o[5:3]), |(n[2:0] & ~o[2:0])};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high at an edge.
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rd2 = prdata2;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task finish_test;
        if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ta, tr, fa, fr, va, pev} = '0;
        {pa, pb, pc, nl, flags, nl2, flags2} = '0;
        pstrb = 4'hF;
        seed = 32'hBF13;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_COMP_MODE_CONFIG, 32'h0);
        check(rd, 32'h1FF);
        check({ang_vc, ang_vp, ang_cp}, 3'h4);
        apb(1'b0, 16'hE610, 32'h0);
        check(rd, 32'h0);
        check(er, 32'h1);
        // Every selection pattern on each output, with all four angle codes.
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pa <= seed[23:0];
            pb <= seed[31:8];
            pc <= {seed[11:0], seed[31:20]};
            w = {seed[31:11], i[1:0], i[0], i[2:1], ~i[2:0], i[2:0]};
            apb(1'b1, `ADDR_COMP_MODE_CONFIG, w);
            apb(1'b0, `ADDR_COMP_MODE_CONFIG, 32'h0);
            check(rd, {21'h0, w[10:0]});
            check(s1, tsum(w[2:0]));
            check(s2, tsum(w[5:3]));
            check(s3, tsum(w[8:6]));
            check({ang_vc, ang_vp, ang_cp}, 3'h4 >> w[10:9]);
        end
        // Random no-load levels; flags are sticky and cleared by writing ones.
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            @(posedge pclk);
            {va, fr, fa, tr, ta} <= seed[14:0];
            pev <= seed[31:16];
            nl_new = {seed[14:12], seed[11:9] & seed[8:6], seed[5:3] & seed[2:0]};
            nl2_new = {seed[14:12], 3'h0, seed[2:0]};
            flags = flags | rises(nl_new, nl);
            flags2 = flags2 | rises(nl2_new, nl2);
            nl = nl_new;
            nl2 = nl2_new;
            // Flags are read first, so the read lands right after the level change.
            apb(1'b0, `ADDR_MAIN_INT_STATUS, 32'h0);
            check(rd, {29'h0, flags});
            check(rd2, {29'h0, flags2});
            apb(1'b1, `ADDR_PHASE_NOLOAD_STATUS, ~seed);
            apb(1'b0, `ADDR_PHASE_NOLOAD_STATUS, 32'h0);
            check(rd, {23'h0, nl});
            check(rd2, {23'h0, nl2});
            apb(1'b0, `ADDR_PHASE_EVENT_STATUS, 32'h0);
            check(rd, {16'h0, pev & `PES_VALID_MASK});
            if (i[0]) begin
                apb(1'b1, `ADDR_MAIN_INT_STATUS, 32'h7);
                flags = 3'h0;
                flags2 = 3'h0;
            end
        end
        // A second reset in mid-run restores the defaults.
        @(posedge pclk);
        {ta, tr, fa, fr, va} <= '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_COMP_MODE_CONFIG, 32'h0);
        check(rd, 32'h1FF);
        apb(1'b0, `ADDR_MAIN_INT_STATUS, 32'h0);
        check(rd, 32'h0);
        check(rd2, 32'h0);
        check(s1, tsum(3'h7));
        check(s2, tsum(3'h7));
        check(s3, tsum(3'h7));
        check({ang_vc, ang_vp, ang_cp}, 3'h4);
        finish_test();
    end
endmodule
bind noload_status_cf_phase_select noload_chk #(.HAS_REACTIVE(HAS_REACTIVE),
    .HAS_FUNDAMENTAL(HAS_FUNDAMENTAL)) u_noload_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .total_active_noload(total_active_noload),
    .total_reactive_noload(total_reactive_noload), .fund_active_noload(fund_active_noload),
    .fund_reactive_noload(fund_reactive_noload), .apparent_noload(apparent_noload),
    .angle_volt_curr_en(angle_volt_curr_en), .angle_volt_pair_en(angle_volt_pair_en),
    .angle_curr_pair_en(angle_curr_pair_en));
`default_nettype wire
